// ### hdl/mtio_core.sv
// Purpose: Digital I/O expansion for motion task selection, start and status
// Assumes: Inputs synchronous to core_clk; motion engine accepts one-cycle commands
// Notes: Function maps are static configuration ports
// Function
// - Fourteen inputs, eight outputs, each slot's function set by configuration.
// - Block number is unsigned binary on eight selects, bit 0 least significant.
// - Each output follows its condition within ten milliseconds.
// - Expansion home input used only when no base input is home.
// - Warning clear clears following-error and response-monitor warnings.
// - Next-task start launches follow-on task only after target reached.
// - A base-unit input may also request the next-task start.
// - Jog rising edge starts jog, falling edge cancels it.
// - Green lamp on with aux supply; red lamp on output fault.
// - Task start begins the task numbered by the selects.
// - In-position output high when target lies within window.
// - Following-error output low when deviation exceeds window.
module mtio_core #(
    parameter int FILT = mtio_pkg::FILT_LEN,
    parameter int START_CYC = mtio_pkg::START_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [mtio_pkg::NUM_IN-1:0] pin_in,
    input wire logic [mtio_pkg::NUM_IN*mtio_pkg::FN_W-1:0] in_fn_cfg,
    input wire logic [mtio_pkg::NUM_OUT*mtio_pkg::FN_W-1:0] out_fn_cfg,
    input wire logic base_home_cfg,
    input wire logic base_home_in,
    input wire logic base_next_in,
    input wire mtio_pkg::mtio_stat_t stat_in,
    input wire logic following_error_warning,
    input wire logic response_monitor_warning,
    input wire logic aux_supply_ok,
    input wire logic out_fault,
    output logic [mtio_pkg::NUM_OUT-1:0] pin_out,
    output mtio_pkg::mtio_cmd_t cmd_q,
    output logic home_switch_q,
    output logic warn_clear_following,
    output logic warn_clear_response,
    output logic led_green,
    output logic led_red
);
    import mtio_pkg::*;

    typedef enum logic [1:0] {
        MTIO_IDLE = 2'b00,
        MTIO_WAIT = 2'b01,
        MTIO_GO = 2'b11
    } mtio_st_t;

    logic [NUM_IN-1:0] filt_q;
    logic [NUM_IN-1:0] filt_prev_q;
    logic [NUM_IN-1:0][$clog2(FILT+1)-1:0] cnt_q;
    logic [7:0] sel;
    logic f_home, f_wclr, f_next, f_jog, f_start;
    logic p_home, p_wclr, p_next, p_jog, p_start;
    logic [7:0] block_q;
    mtio_st_t st_q;
    logic pend_next_q;
    logic [NUM_OUT-1:0] out_q;

    // Counter filter: a level must persist FILT samples to be taken
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_q[gi] <= '0;
                    filt_q[gi] <= 1'b0;
                end else if (pin_in[gi] == filt_q[gi]) begin
                    cnt_q[gi] <= '0;
                end else if (cnt_q[gi] == ($clog2(FILT+1))'(FILT - 1)) begin
                    cnt_q[gi] <= '0;
                    filt_q[gi] <= pin_in[gi];
                end else begin
                    cnt_q[gi] <= cnt_q[gi] + 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_prev_q <= '0;
        end else begin
            filt_prev_q <= filt_q;
        end
    end

    // Function routing from configured input slots; duplicated slots are ORed
    logic [NUM_IN-1:0][FN_W-1:0] in_fn;
    assign in_fn = in_fn_cfg;
    always_comb begin
        sel = 8'h00;
        {f_home, f_wclr, f_next, f_jog, f_start} = 5'h00;
        {p_home, p_wclr, p_next, p_jog, p_start} = 5'h00;
        for (int i = 0; i < NUM_IN; i++) begin
            // Codes below the home code pick a select bit
            if (in_fn[i] < FI_HOME) begin
                sel[in_fn[i][2:0]] = sel[in_fn[i][2:0]] | filt_q[i];
            end
            case (in_fn[i])
                FI_HOME: begin
                    f_home = f_home | filt_q[i];
                    p_home = p_home | filt_prev_q[i];
                end
                FI_WCLR: begin
                    f_wclr = f_wclr | filt_q[i];
                    p_wclr = p_wclr | filt_prev_q[i];
                end
                FI_NEXT: begin
                    f_next = f_next | filt_q[i];
                    p_next = p_next | filt_prev_q[i];
                end
                FI_JOG: begin
                    f_jog = f_jog | filt_q[i];
                    p_jog = p_jog | filt_prev_q[i];
                end
                FI_START: begin
                    f_start = f_start | filt_q[i];
                    p_start = p_start | filt_prev_q[i];
                end
                default: begin
                end
            endcase
        end
    end

    // Start: latch selects on rising edge, launch after a bounded settle
    logic [$clog2(START_CYC+1)-1:0] dly_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= MTIO_IDLE;
            block_q <= 8'h00;
            dly_q <= '0;
        end else begin
            unique case (st_q)
                MTIO_IDLE: if (f_start && !p_start) begin
                    block_q <= sel;
                    dly_q <= '0;
                    st_q <= MTIO_WAIT;
                end
                MTIO_WAIT: begin
                    // Fixed short settle well inside the start budget
                    dly_q <= dly_q + 1'b1;
                    if (dly_q == ($clog2(START_CYC+1))'(1)) begin
                        st_q <= MTIO_GO;
                    end
                end
                MTIO_GO: st_q <= MTIO_IDLE;
                default: st_q <= MTIO_IDLE;
            endcase
        end
    end

    // Next-task request is held until the running task is in position
    logic next_req;
    assign next_req = (f_next && !p_next) || base_next_in;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_next_q <= 1'b0;
        end else if (next_req && !stat_in.in_position) begin
            pend_next_q <= 1'b1;
        end else if (stat_in.in_position) begin
            pend_next_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '0;
        end else begin
            cmd_q.start <= (st_q == MTIO_GO);
            cmd_q.block <= block_q;
            cmd_q.next_start <= (next_req || pend_next_q) && stat_in.in_position;
            cmd_q.jog_start <= f_jog && !p_jog;
            cmd_q.jog_stop <= !f_jog && p_jog;
            cmd_q.warn_clear <= f_wclr && !p_wclr;
        end
    end

    assign warn_clear_following = cmd_q.warn_clear && following_error_warning;
    assign warn_clear_response = cmd_q.warn_clear && response_monitor_warning;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            home_switch_q <= 1'b0;
        end else begin
            home_switch_q <= base_home_cfg ? base_home_in : f_home;
        end
    end

    // Outputs registered each cycle, far inside the response budget
    genvar go;
    generate
        for (go = 0; go < NUM_OUT; go++) begin : g_out
            logic [FN_W-1:0] fo;
            assign fo = out_fn_cfg[go*FN_W +: FN_W];
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    out_q[go] <= 1'b0;
                end else if (fo == FO_IN_POSITION_OUT) begin
                    out_q[go] <= stat_in.in_position;
                end else if (fo == FO_FERR_N) begin
                    out_q[go] <= !stat_in.following_error;
                end else if (fo >= FO_PREG0 && fo < FO_PREG0 + 4'h6) begin
                    out_q[go] <= stat_in.pos_reg[3'(fo - FO_PREG0)];
                end else begin
                    out_q[go] <= 1'b0;
                end
            end
        end
    endgenerate
    assign pin_out = out_q;

    assign led_green = aux_supply_ok;
    assign led_red = out_fault;

    chk_start_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
        (st_q == MTIO_IDLE && f_start && !p_start) |-> ##[1:6] cmd_q.start)
        else $error("start not issued in time");
    chk_block_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
        (st_q == MTIO_IDLE && f_start && !p_start) |=> (block_q == $past(sel)))
        else $error("block number not latched at start edge");
    chk_next_gated: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_q.next_start |-> $past(stat_in.in_position))
        else $error("next task started before in position");
    chk_next_base: assert property (@(posedge core_clk) disable iff (!rst_b)
        (base_next_in && stat_in.in_position) |=> cmd_q.next_start)
        else $error("base next start request ignored");
    chk_jog_edges: assert property (@(posedge core_clk) disable iff (!rst_b)
        (f_jog && !p_jog) |=> cmd_q.jog_start && !cmd_q.jog_stop)
        else $error("jog start missing on rising edge");
    chk_home_select: assert property (@(posedge core_clk) disable iff (!rst_b)
        base_home_cfg |=> home_switch_q == $past(base_home_in))
        else $error("expansion home used while base home configured");
    chk_out_ferr: assert property (@(posedge core_clk) disable iff (!rst_b)
        (out_fn_cfg[7:4] == FO_FERR_N) |=>
        pin_out[1] == !$past(stat_in.following_error))
        else $error("following error output wrong polarity");
    chk_out_in_position_out: assert property (@(posedge core_clk) disable iff (!rst_b)
        (out_fn_cfg[3:0] == FO_IN_POSITION_OUT) |=> pin_out[0] == $past(stat_in.in_position))
        else $error("in position output wrong");
    chk_warn_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        (f_wclr && !p_wclr) |=> cmd_q.warn_clear ##1 !cmd_q.warn_clear)
        else $error("warning clear pulse wrong");
    chk_filter_len: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(filt_q[0]) |-> $past(pin_in[0]) && $past(pin_in[0], FILT))
        else $error("filter passed unsampled level");
endmodule : mtio_core

// ### hdl/mtio_pkg.sv
// Purpose: Shared constants and types for the motion task I/O expansion logic
// Assumes: 20 MHz core clock
// Notes: Function codes select what each input or output slot does
package mtio_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int NUM_IN = 14;
    localparam int NUM_OUT = 8;
    localparam int FN_W = 4;
    // Times in microseconds
    localparam int START_DELAY_US = 2000;
    localparam int OUT_RESP_US = 10000;
    localparam int START_DELAY_CYC = START_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int OUT_RESP_CYC = OUT_RESP_US * (CLK_HZ / 1_000_000);
    localparam int FILT_LEN = 4;
    // Input function codes
    localparam logic [3:0] FI_SEL0 = 4'h0;
    localparam logic [3:0] FI_HOME = 4'h8;
    localparam logic [3:0] FI_WCLR = 4'h9;
    localparam logic [3:0] FI_NEXT = 4'ha;
    localparam logic [3:0] FI_JOG = 4'hb;
    localparam logic [3:0] FI_START = 4'hc;
    localparam logic [3:0] FI_NONE = 4'hf;
    // Output function codes
    localparam logic [3:0] FO_IN_POSITION_OUT = 4'h0;
    localparam logic [3:0] FO_FERR_N = 4'h1;
    localparam logic [3:0] FO_PREG0 = 4'h2;
    localparam logic [3:0] FO_LOW = 4'hf;
    typedef struct packed {
        logic start;
        logic [7:0] block;
        logic next_start;
        logic jog_start;
        logic jog_stop;
        logic warn_clear;
    } mtio_cmd_t;
    typedef struct packed {
        logic in_position;
        logic following_error;
        logic [5:0] pos_reg;
    } mtio_stat_t;
endpackage : mtio_pkg

// ### test/mtio_plc.sv
// Purpose: Controller-side model driving the expansion inputs
// Assumes: Tasks are called just after a falling clock edge
// Notes: Address settle time is a parameter so runs stay short
module mtio_plc #(
    parameter int ADDR_CYC = 20
) (
    input wire logic core_clk,
    output logic [13:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = '0;
    task automatic set_pin(input int i, input logic v);
        pin[i] = v;
    endtask : set_pin
    task automatic start_task(input logic [7:0] blk);
        pin[7:0] = blk;
        // Selects settle before the start edge is raised
        repeat (ADDR_CYC) @(negedge core_clk);
        pin[12] = 1'b1;
    endtask : start_task
endmodule : mtio_plc

// ### test/testbench.sv
// Purpose: Self-checking bench for the motion task I/O expansion
// Assumes: Default slot map, selects on slots 0..7
// Notes: Pulses are counted over fixed windows
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [13:0] pin_in;
    logic [55:0] in_fn_cfg = 56'hfcba9876543210;
    logic [31:0] out_fn_cfg = 32'h76543210;
    logic base_home_cfg = 1'b0;
    logic base_home_in = 1'b0;
    logic base_next_in = 1'b0;
    mtio_pkg::mtio_stat_t stat_in = '0;
    logic fe_w = 1'b0;
    logic rm_w = 1'b0;
    logic aux = 1'b0;
    logic fault = 1'b0;
    logic [7:0] pin_out;
    mtio_pkg::mtio_cmd_t cmd_q;
    logic home_q, wcf, wcr, led_g, led_r;
    wire logic [14:0] obs = {wcf, wcr, cmd_q};
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] c;
    logic [7:0] c1;
    always #25 core_clk = ~core_clk;
    mtio_plc #(.ADDR_CYC(20)) mtio_plc_inst (.core_clk(core_clk), .pin(pin_in));
    mtio_core mtio_core_inst (.core_clk(core_clk), .rst_b(rst_b), .pin_in(pin_in),
        .in_fn_cfg(in_fn_cfg), .out_fn_cfg(out_fn_cfg), .base_home_cfg(base_home_cfg),
        .base_home_in(base_home_in), .base_next_in(base_next_in), .stat_in(stat_in),
        .following_error_warning(fe_w), .response_monitor_warning(rm_w),
        .aux_supply_ok(aux), .out_fault(fault), .pin_out(pin_out), .cmd_q(cmd_q),
        .home_switch_q(home_q), .warn_clear_following(wcf), .warn_clear_response(wcr),
        .led_green(led_g), .led_red(led_r));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Counts the cycles in which one observed bit is high
    task automatic count_bit(input int b, input int lim, output logic [7:0] n);
        n = 8'h00;
        repeat (lim) begin
            @(negedge core_clk);
            if (obs[b] === 1'b1) n = n + 8'h01;
        end
    endtask : count_bit
    task automatic t_start(input logic [7:0] blk);
        mtio_plc_inst.start_task(blk);
        count_bit(12, 20, c);
        check(c, 8'h01);
        check(cmd_q.block, blk);
        // Selects move after the edge; the launched number must not
        mtio_plc_inst.pin[7:0] = ~blk;
        count_bit(12, 12, c);
        check(c, 8'h00);
        check(cmd_q.block, blk);
        mtio_plc_inst.set_pin(12, 1'b0);
        count_bit(12, 12, c);
        check(c, 8'h00);
    endtask : t_start
    task automatic t_glitch();
        mtio_plc_inst.set_pin(12, 1'b1);
        repeat (2) @(negedge core_clk);
        mtio_plc_inst.set_pin(12, 1'b0);
        count_bit(12, 16, c);
        check(c, 8'h00);
    endtask : t_glitch
    task automatic t_pulse(input int slot, input int b);
        mtio_plc_inst.set_pin(slot, 1'b1);
        count_bit(b, 10, c);
        check(c, 8'h01);
        mtio_plc_inst.set_pin(slot, 1'b0);
        count_bit(b == 2 ? 1 : b, 10, c);
        check(c, b == 2 ? 8'h01 : 8'h00);
    endtask : t_pulse
    task automatic t_next();
        stat_in.in_position = 1'b0;
        mtio_plc_inst.set_pin(10, 1'b1);
        count_bit(3, 16, c);
        check(c, 8'h00);
        stat_in.in_position = 1'b1;
        count_bit(3, 10, c);
        check(c, 8'h01);
        mtio_plc_inst.set_pin(10, 1'b0);
        base_next_in = 1'b1;
        @(negedge core_clk);
        c1 = {7'h00, cmd_q.next_start};
        base_next_in = 1'b0;
        count_bit(3, 10, c);
        check(c + c1, 8'h01);
    endtask : t_next
    task automatic t_home(input logic cfg, input logic bh, input logic ph, input logic exp);
        base_home_cfg = cfg;
        base_home_in = bh;
        mtio_plc_inst.set_pin(8, ph);
        repeat (8) @(negedge core_clk);
        check({7'h00, home_q}, {7'h00, exp});
    endtask : t_home
    task automatic t_out(input logic [7:0] st, input logic [7:0] exp);
        stat_in = st;
        repeat (3) @(negedge core_clk);
        check(pin_out, exp);
    endtask : t_out
    task automatic t_led(input logic a, input logic f, input logic [7:0] exp);
        aux = a;
        fault = f;
        @(negedge core_clk);
        check({6'h00, led_g, led_r}, exp);
    endtask : t_led
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(50 * 5000);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        t_start(8'hae);
        t_start(8'h81);
        t_glitch();
        t_pulse(11, 2);
        fe_w = 1'b1;
        rm_w = 1'b1;
        t_pulse(9, 14);
        t_pulse(9, 13);
        t_next();
        t_home(1'b0, 1'b0, 1'b1, 1'b1);
        t_home(1'b1, 1'b0, 1'b1, 1'b0);
        t_home(1'b1, 1'b1, 1'b0, 1'b1);
        t_out(8'hed, 8'hb5);
        t_out(8'h12, 8'h4a);
        out_fn_cfg[3:0] = mtio_pkg::FO_LOW;
        t_out(8'h80, 8'h02);
        t_led(1'b1, 1'b0, 8'h02);
        t_led(1'b0, 1'b1, 8'h01);
        tally_and_finish();
    end
endmodule : testbench
